// *** shared/smc_map.svh ***
// Offsets, field positions, field values, synchroniser lanes and timing counts of the supply monitor control
`ifndef SMC_MAP_SVH
`define SMC_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SMC_OFS_UVCR 8'h00
`define SMC_OFS_OSCTR 8'h04
`define SMC_OFS_REGCR 8'h08
`define SMC_OFS_ISMCR 8'h0C
`define SMC_OFS_UNLOCK 8'h10
`define SMC_OFS_STATUS 8'h14
`define SMC_UNLOCK_KEY 8'hAA

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SMC_UV_THRESHOLD_HYSTERESIS_BIT 2
`define SMC_UV_LVL_LSB 8
`define SMC_FCD 16
`define SMC_SFV 31
`define SMC_RG_SEL_LSB 4
`define SMC_RG_EN 8
`define SMC_RG_ON 9
`define SMC_RG_OK 10
`define SMC_RG_HPEN 12
`define SMC_RG_HPST 13
`define SMC_RG_HPIG 14
`define SMC_IS_TRIM_LSB 4
`define SMC_IS_RATE_LSB 8
`define SMC_IS_FS 12
`define SMC_IS_ON 13

// ----------------------------------------------------------------
// Field values, synchroniser lanes and timing
// ----------------------------------------------------------------
`define SMC_UV_CTRL_RST 2'h1
`define SMC_UV_CTRL_FLAG 2'h2
`define SMC_IS_CTRL_IRQ 2'h1
`define SMC_IS_CTRL_RST 2'h2
`define SMC_SY_UV 0
`define SMC_SY_ISM 1
`define SMC_SY_ROK 2
`define SMC_SY_RON 3
`define SMC_SY_HPON 4
`define SMC_SY_HPIG 5
`define SMC_SY_W 6
`define SMC_UV_MASK_CYC 2'h2

`endif

// *** shared/smc_pkg.sv ***
// Types of the supply monitor control
package smc_pkg;

  typedef enum logic [1:0] {
    SMC_ST_LOAD = 2'b01,
    SMC_ST_RUN = 2'b10
  } smc_state_t;

  typedef enum logic [1:0] {
    SMC_RK_POR = 2'b00,
    SMC_RK_HPOR = 2'b01,
    SMC_RK_UV = 2'b10,
    SMC_RK_OTHER = 2'b11
  } smc_rkind_t;

  typedef struct packed {
    smc_state_t st;
    smc_rkind_t rk;
    logic [1:0] uv_ctrl;
    logic uv_threshold_hysteresis_bit;
    logic [5:0] uv_lvl;
    logic uv_fcd;
    logic [9:0] osc_trim;
    logic osc_fcd;
    logic [3:0] reg_trim;
    logic [2:0] reg_sel;
    logic reg_en;
    logic hpor_en;
    logic hpor_ign;
    logic reg_fcd;
    logic reg_sfv;
    logic lvl_pend;
    logic [1:0] ism_ctrl;
    logic [3:0] ism_trim;
    logic [3:0] ism_rate;
    logic ism_fs;
    logic ism_fcd;
    logic ism_sfv;
    logic [3:0] smp_cnt;
    logic smp_act;
    logic mask_rc;
    logic rc_ref;
    logic [1:0] mask_cnt;
    logic [5:0] s1;
    logic [5:0] s2;
    logic uv_flag;
    logic ism_flag;
    logic uv_rst;
    logic ism_por;
    logic uv_irq;
    logic ism_irq;
    logic acc_err;
    logic unl_ok;
    logic [7:0] unl_addr;
    logic ap_v;
    logic ap_w;
    logic [7:0] ap_a;
    logic [31:0] rdata;
  } smc_regs_t;

endpackage

// *** core/smc_core.sv ***
// Supply monitor control: undervoltage monitor, trims, regulator and input-supply monitor
//
// Our own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "smc_map.svh"

module smc_core (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Reset sequencing
  input wire logic rst_evt,
  input wire logic [1:0] rst_kind,
  input wire logic wake_evt,
  output logic cpu_run,
  // Fuse values
  input wire logic [1:0] fuse_uv_ctrl,
  input wire logic fuse_uv_threshold_hysteresis_bit,
  input wire logic [5:0] fuse_uv_lvl,
  input wire logic [9:0] fuse_osc_trim,
  input wire logic [3:0] fuse_reg_trim,
  input wire logic [3:0] fuse_ism_trim,
  // System state
  input wire logic dbg_active,
  input wire logic sys_rc_clk,
  input wire logic slow_rc_tick,
  input wire logic deep_sleep,
  // Analog detector outputs, asynchronous
  input wire logic uv_det_async,
  input wire logic ism_det_async,
  input wire logic reg_ok_async,
  input wire logic reg_on_async,
  input wire logic hpor_on_async,
  input wire logic hpor_ign_async,
  // Analog controls
  output logic uv_enable,
  output logic uv_threshold_hysteresis_bit_en,
  output logic [5:0] uv_level,
  output logic [9:0] osc_trim,
  output logic [3:0] reg_trim,
  output logic [2:0] reg_level,
  output logic reg_enable,
  output logic hpor_enable,
  output logic hpor_ignore,
  output logic [3:0] ism_trim,
  output logic ism_enable,
  output logic slow_rc_req,
  // Reset requests and interrupt sources
  output logic uv_reset_req,
  output logic ism_por_req,
  output logic uv_irq,
  output logic ism_irq,
  output logic access_err
);

  smc_pkg::smc_regs_t r;
  smc_pkg::smc_regs_t n;
  logic masked;
  logic sampling;
  logic ism_on;
  logic full;
  logic prot;
  logic grant;
  logic [31:0] rd;
  logic [31:0] st_word;

  // ----------------------------------------------------------------
  // Register read view
  // ----------------------------------------------------------------
  always_comb
  begin
    masked = r.mask_rc | (r.mask_cnt != 2'h0) | (r.uv_ctrl == 2'h0);
    sampling = (r.ism_ctrl != 2'h0) & (deep_sleep | r.ism_fs);
    ism_on = (r.ism_ctrl != 2'h0) & (~sampling | r.smp_act);
    st_word = {26'h0, ism_on, r.s2[`SMC_SY_HPON], r.s2[`SMC_SY_RON],
      r.s2[`SMC_SY_ROK] & ~r.lvl_pend, r.ism_flag, r.uv_flag};
    rd = 32'h0;
    if (haddr[7:0] == `SMC_OFS_UVCR)
    begin
      rd[1:0] = r.uv_ctrl;
      rd[`SMC_UV_THRESHOLD_HYSTERESIS_BIT] = r.uv_threshold_hysteresis_bit;
      rd[`SMC_UV_LVL_LSB +: 6] = r.uv_lvl;
      rd[`SMC_FCD] = r.uv_fcd;
    end
    else if (haddr[7:0] == `SMC_OFS_OSCTR)
    begin
      rd[9:0] = r.osc_trim;
      rd[`SMC_FCD] = r.osc_fcd;
    end
    else if (haddr[7:0] == `SMC_OFS_REGCR)
    begin
      rd[3:0] = r.reg_trim;
      rd[`SMC_RG_SEL_LSB +: 3] = r.reg_sel;
      rd[`SMC_RG_EN] = r.reg_en;
      rd[`SMC_RG_ON] = r.s2[`SMC_SY_RON];
      rd[`SMC_RG_OK] = r.s2[`SMC_SY_ROK] & ~r.lvl_pend;
      rd[`SMC_RG_HPEN] = r.hpor_en;
      rd[`SMC_RG_HPST] = r.s2[`SMC_SY_HPON];
      rd[`SMC_RG_HPIG] = r.s2[`SMC_SY_HPIG];
      rd[`SMC_FCD] = r.reg_fcd;
      rd[`SMC_SFV] = r.reg_sfv;
    end
    else if (haddr[7:0] == `SMC_OFS_ISMCR)
    begin
      rd[1:0] = r.ism_ctrl;
      rd[`SMC_IS_TRIM_LSB +: 4] = r.ism_trim;
      rd[`SMC_IS_RATE_LSB +: 4] = r.ism_rate;
      rd[`SMC_IS_FS] = r.ism_fs;
      rd[`SMC_IS_ON] = ism_on;
      rd[`SMC_FCD] = r.ism_fcd;
      rd[`SMC_SFV] = r.ism_sfv;
    end
    else if (haddr[7:0] == `SMC_OFS_STATUS)
    begin
      rd = st_word;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    n = r;
    n.uv_irq = 1'b0;
    n.ism_irq = 1'b0;
    n.acc_err = 1'b0;
    // Detector synchroniser
    n.s1 = {hpor_ign_async, hpor_on_async, reg_on_async, reg_ok_async,
      ism_det_async, uv_det_async};
    n.s2 = r.s1;
    // Address phase capture, read data launched for the data phase
    n.ap_v = hsel & hready & htrans[1];
    n.ap_w = hwrite;
    n.ap_a = haddr[7:0];
    n.rdata = (hsel & hready & htrans[1] & ~hwrite) ? rd : r.rdata;
    // Level change acknowledged once the good signal drops; a new change wins
    if (r.lvl_pend && !r.s2[`SMC_SY_ROK])
    begin
      n.lvl_pend = 1'b0;
    end
    // Data phase write
    prot = (r.ap_a == `SMC_OFS_UVCR) | (r.ap_a == `SMC_OFS_OSCTR) |
      (r.ap_a == `SMC_OFS_REGCR) | (r.ap_a == `SMC_OFS_ISMCR);
    grant = prot & r.unl_ok & (r.unl_addr == r.ap_a);
    if (r.ap_v & r.ap_w)
    begin
      if (prot)
      begin
        n.unl_ok = 1'b0;
        n.acc_err = ~grant;
      end
      if (r.ap_a == `SMC_OFS_UNLOCK && hwdata[31:24] == `SMC_UNLOCK_KEY)
      begin
        n.unl_ok = 1'b1;
        n.unl_addr = hwdata[7:0];
      end
      if (grant && r.ap_a == `SMC_OFS_UVCR)
      begin
        n.uv_ctrl = hwdata[1:0];
        n.uv_threshold_hysteresis_bit = hwdata[`SMC_UV_THRESHOLD_HYSTERESIS_BIT];
        n.uv_lvl = hwdata[`SMC_UV_LVL_LSB +: 6];
        n.uv_fcd = hwdata[`SMC_FCD];
      end
      else if (grant && r.ap_a == `SMC_OFS_OSCTR)
      begin
        n.osc_trim = hwdata[9:0];
        n.osc_fcd = hwdata[`SMC_FCD];
      end
      else if (grant && r.ap_a == `SMC_OFS_REGCR && !r.reg_sfv)
      begin
        n.reg_trim = hwdata[3:0];
        n.reg_sel = hwdata[`SMC_RG_SEL_LSB +: 3];
        n.lvl_pend = n.lvl_pend | (hwdata[`SMC_RG_SEL_LSB +: 3] != r.reg_sel);
        n.reg_en = hwdata[`SMC_RG_EN];
        n.hpor_en = hwdata[`SMC_RG_HPEN];
        n.hpor_ign = hwdata[`SMC_RG_HPIG];
        n.reg_fcd = hwdata[`SMC_FCD];
        n.reg_sfv = hwdata[`SMC_SFV];
      end
      else if (grant && r.ap_a == `SMC_OFS_ISMCR && !r.ism_sfv)
      begin
        n.ism_ctrl = hwdata[1:0];
        n.ism_trim = hwdata[`SMC_IS_TRIM_LSB +: 4];
        n.ism_rate = hwdata[`SMC_IS_RATE_LSB +: 4];
        n.ism_fs = hwdata[`SMC_IS_FS];
        n.ism_fcd = hwdata[`SMC_FCD];
        n.ism_sfv = hwdata[`SMC_SFV];
      end
    end
    if (wake_evt)
    begin
      n.reg_en = 1'b1;
    end
    // Reset sequencing: fuse loads before the CPU runs
    full = (r.rk == smc_pkg::SMC_RK_POR) | (r.rk == smc_pkg::SMC_RK_HPOR);
    case (r.st)
      smc_pkg::SMC_ST_LOAD:
      begin
        if (full || r.rk == smc_pkg::SMC_RK_OTHER || !r.uv_fcd)
        begin
          n.uv_ctrl = fuse_uv_ctrl;
          n.uv_threshold_hysteresis_bit = fuse_uv_threshold_hysteresis_bit;
          n.uv_lvl = fuse_uv_lvl;
          n.uv_fcd = (r.rk == smc_pkg::SMC_RK_UV) ? 1'b1 : r.uv_fcd | full;
        end
        if (full || !r.osc_fcd)
        begin
          n.osc_trim = fuse_osc_trim;
          n.osc_fcd = 1'b1;
        end
        if (full || !r.reg_fcd)
        begin
          n.reg_trim = fuse_reg_trim;
          n.reg_fcd = 1'b1;
        end
        if (full || !r.ism_fcd)
        begin
          n.ism_trim = fuse_ism_trim;
          n.ism_fcd = 1'b1;
        end
        if (full)
        begin
          n.reg_sfv = 1'b0;
          n.ism_sfv = 1'b0;
          n.reg_en = 1'b1;
          n.hpor_en = 1'b1;
          n.hpor_ign = 1'b0;
          n.ism_ctrl = 2'h0;
          n.ism_fs = 1'b0;
          n.ism_rate = 4'h0;
        end
        n.st = smc_pkg::SMC_ST_RUN;
      end
      default:
      begin
        if (rst_evt)
        begin
          n.st = smc_pkg::SMC_ST_LOAD;
          n.rk = smc_pkg::smc_rkind_t'(rst_kind);
        end
      end
    endcase
    // Detector masking after enable
    if (r.uv_ctrl == 2'h0 && n.uv_ctrl != 2'h0)
    begin
      n.mask_rc = 1'b1;
      n.rc_ref = sys_rc_clk;
      n.mask_cnt = 2'h0;
    end
    else if (r.mask_rc && sys_rc_clk != r.rc_ref)
    begin
      n.mask_rc = 1'b0;
      n.mask_cnt = `SMC_UV_MASK_CYC;
    end
    else if (r.mask_cnt != 2'h0)
    begin
      n.mask_cnt = r.mask_cnt - 2'h1;
    end
    // Sampling timer on slow RC ticks
    if (!sampling)
    begin
      n.smp_cnt = 4'h0;
      n.smp_act = 1'b0;
    end
    else if (slow_rc_tick)
    begin
      n.smp_act = (r.smp_cnt == r.ism_rate);
      n.smp_cnt = (r.smp_cnt == r.ism_rate) ? 4'h0 : r.smp_cnt + 4'h1;
    end
    // Flags, requests and interrupt sources
    n.uv_flag = (r.uv_ctrl == `SMC_UV_CTRL_FLAG) & r.s2[`SMC_SY_UV] & ~masked;
    n.uv_rst = (r.uv_ctrl == `SMC_UV_CTRL_RST) & r.s2[`SMC_SY_UV] & ~masked &
      ~dbg_active;
    n.uv_irq = n.uv_flag & ~r.uv_flag & ~dbg_active;
    n.ism_flag = (r.ism_ctrl == `SMC_IS_CTRL_IRQ) & r.s2[`SMC_SY_ISM] & ism_on;
    n.ism_por = (r.ism_ctrl == `SMC_IS_CTRL_RST) & r.s2[`SMC_SY_ISM] & ism_on;
    n.ism_irq = n.ism_flag & ~r.ism_flag;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r <= '0;
      r.st <= smc_pkg::SMC_ST_LOAD;
      r.rk <= smc_pkg::SMC_RK_POR;
      r.reg_en <= 1'b1;
      r.hpor_en <= 1'b1;
    end
    else
    begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r.rdata;
  assign cpu_run = (r.st == smc_pkg::SMC_ST_RUN);
  assign uv_enable = (r.uv_ctrl != 2'h0);
  assign uv_threshold_hysteresis_bit_en = r.uv_threshold_hysteresis_bit;
  assign uv_level = r.uv_lvl;
  assign osc_trim = r.osc_trim;
  assign reg_trim = r.reg_trim;
  assign reg_level = r.reg_sel;
  assign reg_enable = r.reg_en;
  assign hpor_enable = r.hpor_en;
  assign hpor_ignore = r.hpor_ign;
  assign ism_trim = r.ism_trim;
  assign ism_enable = ism_on;
  assign slow_rc_req = sampling;
  assign uv_reset_req = r.uv_rst;
  assign ism_por_req = r.ism_por;
  assign uv_irq = r.uv_irq;
  assign ism_irq = r.ism_irq;
  assign access_err = r.acc_err;

endmodule

// *** tb/smc_core_properties.sv ***
// Concurrent checks on the supply monitor control ports
`timescale 1ns/1ps
module smc_core_chk (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // Sequencing and state
  input wire logic rst_evt,
  input wire logic cpu_run,
  input wire logic dbg_active,
  input wire logic uv_enable,
  input wire logic reg_enable,
  input wire logic hpor_enable,
  // Requests and sources
  input wire logic uv_reset_req,
  input wire logic uv_irq,
  input wire logic ism_irq,
  input wire logic access_err
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence s_load;
    !cpu_run ##1 cpu_run;
  endsequence
  sequence s_masked;
    !uv_reset_req ##1 !uv_reset_req ##1 !uv_reset_req ##1 !uv_reset_req;
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_err_pulse: assert property (access_err |=> !access_err)
    else $error("access error longer than one cycle");
  a_uv_irq_pulse: assert property (uv_irq |=> !uv_irq)
    else $error("undervoltage source longer than one cycle");
  a_ism_irq_pulse: assert property (ism_irq |=> !ism_irq)
    else $error("input monitor source longer than one cycle");
  a_dbg_no_irq: assert property (dbg_active [*3] |-> !uv_irq)
    else $error("undervoltage source during debug");
  a_dbg_no_rst: assert property (dbg_active [*3] |-> !uv_reset_req)
    else $error("undervoltage reset during debug");
  a_enable_mask: assert property ($rose(uv_enable) |-> s_masked)
    else $error("detector not masked after enable");
  a_reload_run: assert property (rst_evt && cpu_run |=> s_load)
    else $error("cpu run not held during reload");
  a_power_on: assert property ($rose(hresetn) |-> reg_enable && hpor_enable)
    else $error("regulator or detector off after power on");
endmodule

bind smc_core smc_core_chk u_chk (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .rst_evt(rst_evt), .cpu_run(cpu_run), .dbg_active(dbg_active), .uv_enable(uv_enable),
  .reg_enable(reg_enable), .hpor_enable(hpor_enable), .uv_reset_req(uv_reset_req),
  .uv_irq(uv_irq), .ism_irq(ism_irq), .access_err(access_err)
);

// *** tb/supply_monitor_control_bench.sv ***
// Self-checking bench of the supply monitor control
`timescale 1ns/1ps
`include "smc_map.svh"
module supply_monitor_control_bench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic rst_evt = 1'b0;
  logic [1:0] rst_kind = 2'h0;
  logic wake_evt = 1'b0;
  logic dbg_active = 1'b0;
  logic sys_rc_clk = 1'b0;
  logic slow_rc_tick = 1'b0;
  logic deep_sleep = 1'b0;
  logic uv_det_async = 1'b0;
  logic ism_det_async = 1'b0;
  logic reg_ok_async = 1'b1;
  logic [9:0] fuse_osc_trim = 10'h2A5;
  logic [3:0] fuse_reg_trim = 4'h9;
  logic hreadyout, hresp, cpu_run, uv_enable, uv_threshold_hysteresis_bit_en, reg_enable, hpor_enable;
  logic hpor_ignore, ism_enable, slow_rc_req, uv_reset_req, ism_por_req;
  logic uv_irq, ism_irq, access_err;
  logic [31:0] hrdata;
  logic [5:0] uv_level;
  logic [9:0] osc_trim;
  logic [3:0] reg_trim, ism_trim;
  logic [2:0] reg_level;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  int ae_n = 0;
  int ui_n = 0;
  int ii_n = 0;
  int en_n = 0;
  int en0 = 0;

  smc_core DUT (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .rst_evt, .rst_kind, .wake_evt,
    .cpu_run, .fuse_uv_ctrl(2'h0), .fuse_uv_threshold_hysteresis_bit(1'b1), .fuse_uv_lvl(6'h15),
    .fuse_osc_trim, .fuse_reg_trim, .fuse_ism_trim(4'h6), .dbg_active, .sys_rc_clk,
    .slow_rc_tick, .deep_sleep, .uv_det_async, .ism_det_async, .reg_ok_async,
    .reg_on_async(reg_enable), .hpor_on_async(hpor_enable), .hpor_ign_async(hpor_ignore),
    .uv_enable, .uv_threshold_hysteresis_bit_en, .uv_level, .osc_trim, .reg_trim, .reg_level, .reg_enable,
    .hpor_enable, .hpor_ignore, .ism_trim, .ism_enable, .slow_rc_req, .uv_reset_req,
    .ism_por_req, .uv_irq, .ism_irq, .access_err
  );

  always #2.5 hclk = ~hclk;

  // ----------------------------------------------------------------
  // Slow clocks, event counters and timeout
  // ----------------------------------------------------------------
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    sys_rc_clk <= cyc[3];
    slow_rc_tick <= (cyc[3:0] == 4'hF);
    ae_n <= ae_n + int'(access_err === 1'b1);
    ui_n <= ui_n + int'(uv_irq === 1'b1);
    ii_n <= ii_n + int'(ism_irq === 1'b1);
    en_n <= en_n + int'(ism_enable === 1'b1);
    if (cyc == 20000)
    begin
      err_total++;
      wrap_up;
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r & m, e);
  endtask

  task automatic unl_wr(input logic [7:0] a, input logic [31:0] d);
    wr(`SMC_OFS_UNLOCK, {`SMC_UNLOCK_KEY, 16'h0, a});
    wr(a, d);
  endtask

  task automatic rst_go(input logic [1:0] k);
    @(posedge hclk);
    rst_evt <= 1'b1;
    rst_kind <= k;
    @(posedge hclk);
    rst_evt <= 1'b0;
    wt(4);
    chk(32'(cpu_run), 32'h1);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    wt(10);
    hresetn <= 1'b1;
    wt(4);
    chk(32'({reg_enable, hpor_enable}), 32'h3);
    chk(32'({uv_enable, ism_enable}), 32'h0);
    chk(32'(osc_trim), 32'h2A5);
    chk(32'({reg_trim, ism_trim}), 32'h96);
    chk(32'({uv_threshold_hysteresis_bit_en, uv_level}), 32'h55);
    rdc(`SMC_OFS_UVCR, 32'hFFFF_FFFF, 32'h0001_1504);
    wr(`SMC_OFS_OSCTR, 32'h0001_03FF);
    wt(3);
    chk(32'(ae_n), 32'h1);
    chk(32'(osc_trim), 32'h2A5);
    unl_wr(`SMC_OFS_UVCR, 32'h0001_0A02);
    wt(20);
    chk(32'({uv_enable, uv_threshold_hysteresis_bit_en, uv_level}), 32'h8A);
    chk(32'(ae_n), 32'h1);
    $display("test protection done");
    uv_det_async <= 1'b1;
    wt(8);
    rdc(`SMC_OFS_STATUS, 32'h1, 32'h1);
    chk(32'({ui_n[3:0], uv_reset_req}), 32'h2);
    uv_det_async <= 1'b0;
    wt(8);
    rdc(`SMC_OFS_STATUS, 32'h1, 32'h0);
    dbg_active <= 1'b1;
    uv_det_async <= 1'b1;
    wt(8);
    chk(32'(ui_n), 32'h1);
    unl_wr(`SMC_OFS_UVCR, 32'h0001_0A01);
    wt(8);
    chk(32'(uv_reset_req), 32'h0);
    dbg_active <= 1'b0;
    wt(8);
    chk(32'(uv_reset_req), 32'h1);
    unl_wr(`SMC_OFS_UVCR, 32'h0001_0A00);
    wt(4);
    chk(32'(uv_reset_req), 32'h0);
    unl_wr(`SMC_OFS_UVCR, 32'h0001_0A01);
    wt(3);
    chk(32'(uv_reset_req), 32'h0);
    wt(17);
    chk(32'(uv_reset_req), 32'h1);
    uv_det_async <= 1'b0;
    unl_wr(`SMC_OFS_UVCR, 32'h0001_0A00);
    $display("test undervoltage done");
    unl_wr(`SMC_OFS_REGCR, 32'h0001_4109);
    wt(6);
    rdc(`SMC_OFS_STATUS, 32'h18, 32'h08);
    unl_wr(`SMC_OFS_REGCR, 32'h0001_5009);
    wt(6);
    chk(32'(reg_enable), 32'h0);
    rdc(`SMC_OFS_STATUS, 32'h38, 32'h10);
    wake_evt <= 1'b1;
    wt(1);
    wake_evt <= 1'b0;
    wt(2);
    chk(32'(reg_enable), 32'h1);
    unl_wr(`SMC_OFS_REGCR, 32'h8001_5153);
    wt(6);
    chk(32'({reg_trim, reg_level}), 32'h1D);
    rdc(`SMC_OFS_STATUS, 32'h4, 32'h0);
    reg_ok_async <= 1'b0;
    wt(4);
    reg_ok_async <= 1'b1;
    wt(4);
    rdc(`SMC_OFS_STATUS, 32'h4, 32'h4);
    rdc(`SMC_OFS_REGCR, 32'h4000, 32'h4000);
    unl_wr(`SMC_OFS_REGCR, 32'h0001_1000);
    wt(3);
    chk(32'({reg_enable, reg_trim}), 32'h13);
    chk(32'(ae_n), 32'h1);
    $display("test regulator done");
    unl_wr(`SMC_OFS_ISMCR, 32'h0001_0161);
    wt(4);
    chk(32'({ism_enable, slow_rc_req}), 32'h2);
    ism_det_async <= 1'b1;
    wt(8);
    chk(32'(ii_n), 32'h1);
    rdc(`SMC_OFS_STATUS, 32'h2, 32'h2);
    ism_det_async <= 1'b0;
    deep_sleep <= 1'b1;
    wt(4);
    chk(32'(slow_rc_req), 32'h1);
    deep_sleep <= 1'b0;
    unl_wr(`SMC_OFS_ISMCR, 32'h0001_1161);
    wt(4);
    chk(32'(slow_rc_req), 32'h1);
    wt(36);
    en0 = en_n;
    wt(32);
    chk(32'(en_n - en0), 32'h10);
    unl_wr(`SMC_OFS_ISMCR, 32'h8001_0162);
    ism_det_async <= 1'b1;
    wt(8);
    chk(32'(ism_por_req), 32'h1);
    ism_det_async <= 1'b0;
    unl_wr(`SMC_OFS_ISMCR, 32'h0001_0061);
    rdc(`SMC_OFS_ISMCR, 32'h8000_0003, 32'h8000_0002);
    $display("test input monitor done");
    unl_wr(`SMC_OFS_OSCTR, 32'h0001_0155);
    rst_go(2'h3);
    chk(32'(osc_trim), 32'h155);
    fuse_osc_trim <= 10'h0C3;
    unl_wr(`SMC_OFS_OSCTR, 32'h0000_0111);
    rst_go(2'h3);
    rdc(`SMC_OFS_OSCTR, 32'hFFFF_FFFF, 32'h0001_00C3);
    unl_wr(`SMC_OFS_UVCR, 32'h0001_0A00);
    rst_go(2'h2);
    chk(32'(uv_level), 32'h0A);
    unl_wr(`SMC_OFS_UVCR, 32'h0000_0A00);
    rst_go(2'h2);
    rdc(`SMC_OFS_UVCR, 32'hFFFF_FFFF, 32'h0001_1504);
    fuse_reg_trim <= 4'hC;
    rst_go(2'h0);
    chk(32'(reg_trim), 32'hC);
    unl_wr(`SMC_OFS_REGCR, 32'h0001_1107);
    wt(3);
    chk(32'(reg_trim), 32'h7);
    $display("test resets done");
    wrap_up;
  end
endmodule
